/* File: hw/debug_run_status_pkg.sv */
// constants, register map and types for the debug run status block
// Overview of operation
// - a new run clears the A match flag
// - A match after arming sets the A flag
// - a new run clears the B match flag
// - B match after arming sets the B flag
// - armed bit mirrors arm while module enabled
// - writing arm one while enabled sets armed
// - run end clears armed without software
// - begin trace ends run when FIFO fills
// - end trace ends run on trigger event
// - writing zero to arm or enable stops
// - a new run clears the valid count
// - count holds valid words, zero to eight
// - FIFO readout never decrements the count
// - break request at trigger or FIFO full
// - enable in bit 7, refused when secured
package debug_run_status_pkg;

  // byte offsets on the register bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] MODE_OFS = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

  // control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_ARM_BIT = 6;
  localparam int CTRL_TAG_BIT = 5;
  localparam int CTRL_BRK_BIT = 4;

  // status register fields
  localparam int STAT_A_BIT = 7;
  localparam int STAT_B_BIT = 6;
  localparam int STAT_ARMED_BIT = 5;

  // mode register: bit 0 set selects begin trace
  localparam int MODE_BEGIN_BIT = 0;

  // interrupt bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_A_BIT = 1;
  localparam int IRQ_B_BIT = 2;
  localparam int IRQ_W = 3;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // FIFO depth in words
  localparam logic [3:0] FIFO_FULL_COUNT = 4'h8;

  typedef enum logic [0:0] {
    RUN_IDLE = 1'b0,
    RUN_ACTIVE = 1'b1
  } run_e;

endpackage

/* File: hw/secure_sync.sv */
// three-stage synchroniser for the chip secured level
`timescale 1ns/1ps
`default_nettype none
module secure_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // asynchronous level in, clean level out
  input wire logic level_in,
  output logic level_out
);

  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } sync_s;

  sync_s q_reg;
  sync_s q_next;

  always_comb begin
    q_next = q_reg;
    q_next.stage = {q_reg.stage[1:0], level_in};
    // stage 0 only feeds stage 1; the level moves once stages 1 and 2 agree
    if (q_reg.stage[1] == q_reg.stage[2]) begin
      q_next.level = q_reg.stage[2];
    end
  end

  // reset assumes secured so that enable cannot slip in before the pin settles
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q_reg <= '{stage: 3'h7, level: 1'b1};
    end else begin
      q_reg <= q_next;
    end
  end

  assign level_out = q_reg.level;

endmodule // secure_sync
`default_nettype wire

/* File: hw/debug_run_status.sv */
// debug run status block with AHB-Lite register slave
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module debug_run_status
  import debug_run_status_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // trace events from comparators and FIFO, same clock
  input wire logic cmp_a_match,
  input wire logic cmp_b_match,
  input wire logic trigger_event,
  input wire logic fifo_push,
  input wire logic fifo_pop,
  // chip security level from a pin
  input wire logic chip_secured,
  // status to the trace logic and the CPU
  output logic armed_out,
  output logic cpu_break_req,
  output logic cpu_break_tag,
  output logic irq
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    run_e run;
    logic flag_a;
    logic flag_b;
    logic [3:0] count;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic brk;
    logic brk_tag;
    logic irq;
    logic armed;
  } state_s;

  state_s q_reg;
  state_s q_next;
  logic secured;

  secure_sync u_secure_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .level_in(chip_secured),
    .level_out(secured)
  );

  // status byte as software sees it
  function automatic logic [7:0] status_byte(input state_s s);
    logic [7:0] v;
    v = 8'h00;
    v[STAT_A_BIT] = s.flag_a;
    v[STAT_B_BIT] = s.flag_b;
    // armed image only while enabled
    v[STAT_ARMED_BIT] = s.ctrl[CTRL_EN_BIT] & s.ctrl[CTRL_ARM_BIT];
    // bit 4 unused, reads zero
    v[3:0] = s.count;
    return v;
  endfunction

  function automatic logic [31:0] read_mux(input state_s s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      CTRL_OFS: v[7:0] = s.ctrl;
      STAT_OFS: v[7:0] = status_byte(s);
      MODE_OFS: v[7:0] = s.mode;
      IRQ_STAT_OFS: v[IRQ_W-1:0] = s.irq_stat;
      IRQ_MASK_OFS: v[IRQ_W-1:0] = s.irq_mask;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_comb begin
    logic active;
    logic begin_mode;
    logic [3:0] cnt;
    logic full_now;
    logic end_hw;
    logic end_sw;
    logic start;
    logic brk_evt;
    logic [IRQ_W-1:0] evt;
    logic [IRQ_W-1:0] w1c;
    logic new_en;
    logic new_arm;
    logic ctrl_wr;
    active = 1'b0;
    begin_mode = 1'b0;
    cnt = 4'h0;
    full_now = 1'b0;
    end_hw = 1'b0;
    end_sw = 1'b0;
    start = 1'b0;
    brk_evt = 1'b0;
    evt = IRQ_RST;
    w1c = IRQ_RST;
    new_en = 1'b0;
    new_arm = 1'b0;
    ctrl_wr = 1'b0;

    q_next = q_reg;
    q_next.brk = 1'b0;
    active = (q_reg.run == RUN_ACTIVE);
    begin_mode = q_reg.mode[MODE_BEGIN_BIT];
    cnt = q_reg.count;

    // address phase: capture writes, prepare read data for the data phase
    q_next.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      q_next.wr_pend = hwrite;
      q_next.wr_addr = {haddr[7:2], 2'b00};
      q_next.rdata = hwrite ? 32'h0000_0000 : read_mux(q_reg, {haddr[7:2], 2'b00});
    end

    if (active) begin
      if (cmp_a_match) begin
        q_next.flag_a = 1'b1;
        evt[IRQ_A_BIT] = ~q_reg.flag_a;
      end
      if (cmp_b_match) begin
        q_next.flag_b = 1'b1;
        evt[IRQ_B_BIT] = ~q_reg.flag_b;
      end
      // count valid words up to eight
      if (fifo_push && (cnt != FIFO_FULL_COUNT)) begin
        cnt = cnt + 4'h1;
      end
      // fifo_pop is deliberately unused by the count
      full_now = (cnt == FIFO_FULL_COUNT);
      end_hw = begin_mode ? full_now : trigger_event;
      brk_evt = end_hw & q_reg.ctrl[CTRL_BRK_BIT];
    end
    q_next.count = cnt;

    // data phase of a write
    if (q_reg.wr_pend) begin
      unique case (q_reg.wr_addr)
        CTRL_OFS: begin
          ctrl_wr = 1'b1;
          // enable cannot be set while secured
          new_en = hwdata[CTRL_EN_BIT] & (q_reg.ctrl[CTRL_EN_BIT] | ~secured);
          new_arm = hwdata[CTRL_ARM_BIT];
          q_next.ctrl = hwdata[7:0];
          q_next.ctrl[CTRL_EN_BIT] = new_en;
          q_next.ctrl[CTRL_ARM_BIT] = new_arm & new_en;
          // zero to arm or enable stops
          end_sw = active & ~(new_arm & new_en);
          start = ~active & new_arm & new_en;
        end
        MODE_OFS: q_next.mode = {7'h00, hwdata[MODE_BEGIN_BIT]};
        IRQ_STAT_OFS: w1c = hwdata[IRQ_W-1:0];
        IRQ_MASK_OFS: q_next.irq_mask = hwdata[IRQ_W-1:0];
        // status and unmapped writes do nothing
        default: ctrl_wr = 1'b0;
      endcase
    end

    if (start) begin
      q_next.run = RUN_ACTIVE;
      q_next.flag_a = 1'b0;
      q_next.flag_b = 1'b0;
      q_next.count = 4'h0;
    end else if (end_hw || end_sw) begin
      q_next.run = RUN_IDLE;
      // run end drops arm by itself
      q_next.ctrl[CTRL_ARM_BIT] = 1'b0;
      evt[IRQ_DONE_BIT] = 1'b1;
    end
    // a hardware end in the same cycle as a control write still disarms
    if (ctrl_wr && end_hw) begin
      q_next.ctrl[CTRL_ARM_BIT] = 1'b0;
    end

    q_next.brk = brk_evt;
    q_next.brk_tag = q_reg.ctrl[CTRL_TAG_BIT];

    // new events win over a write-one-to-clear in the same cycle
    q_next.irq_stat = (q_reg.irq_stat & ~w1c) | evt;
    q_next.irq = |(q_next.irq_stat & q_next.irq_mask);
    q_next.armed = q_next.ctrl[CTRL_EN_BIT] & q_next.ctrl[CTRL_ARM_BIT];
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q_reg <= '{
        ctrl: CTRL_RST,
        mode: MODE_RST,
        run: RUN_IDLE,
        flag_a: 1'b0,
        flag_b: 1'b0,
        count: 4'h0,
        irq_stat: IRQ_RST,
        irq_mask: IRQ_RST,
        wr_pend: 1'b0,
        wr_addr: 8'h00,
        rdata: 32'h0000_0000,
        brk: 1'b0,
        brk_tag: 1'b0,
        irq: 1'b0,
        armed: 1'b0
      };
    end else begin
      q_reg <= q_next;
    end
  end

  // zero-wait slave, always OKAY; hsize is accepted but only words are used
  logic ready_reg;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ready_reg <= 1'b1;
    end else begin
      ready_reg <= 1'b1;
    end
  end

  assign hreadyout = ready_reg;
  assign hresp = q_reg.wr_pend & 1'b0;
  assign hrdata = q_reg.rdata;
  assign armed_out = q_reg.armed;
  assign cpu_break_req = q_reg.brk;
  assign cpu_break_tag = q_reg.brk_tag;
  assign irq = q_reg.irq;

endmodule // debug_run_status
`default_nettype wire

/* File: testbench/debug_run_status_monitor.sv */
// port checker for the debug run status block
`timescale 1ns/1ps
`default_nettype none
module debug_run_status_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // watched ports
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic trigger_event,
  input wire logic armed_out,
  input wire logic cpu_break_req,
  input wire logic irq
);
  // reset must quiet armed_out, cpu_break_req and irq, so no disable here
  chk_reset_quiet: assert property (@(posedge ref_clk)
    srst |=> !armed_out && !cpu_break_req && !irq) else $error("outputs busy after reset");
  chk_ready_high: assert property (@(posedge ref_clk) disable iff (srst)
    hreadyout) else $error("wait state inserted");
  chk_resp_okay: assert property (@(posedge ref_clk) disable iff (srst)
    !hresp) else $error("error response");
  chk_break_pulse: assert property (@(posedge ref_clk) disable iff (srst)
    cpu_break_req |=> !cpu_break_req) else $error("break request longer than a cycle");
  chk_break_idle: assert property (@(posedge ref_clk) disable iff (srst)
    !armed_out [*4] |=> !cpu_break_req) else $error("break request with no run");
  chk_break_source: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(cpu_break_req) |-> $past(armed_out) || $past(armed_out, 2))
    else $error("break request not from a run end");
  chk_armed_drops: assert property (@(posedge ref_clk) disable iff (srst)
    cpu_break_req |=> !armed_out) else $error("armed kept after run end");
  chk_idle_trigger: assert property (@(posedge ref_clk) disable iff (srst)
    trigger_event && !armed_out && $past(armed_out, 2) == 1'b0 |=> !cpu_break_req)
    else $error("break from trigger while idle");
endmodule // debug_run_status_monitor
`default_nettype wire

/* File: testbench/trace_source.sv */
// stand-in for comparators, trigger logic and the trace FIFO reader
`timescale 1ns/1ps
`default_nettype none
module trace_source (
  // clock
  input wire logic ref_clk,
  // events: a match, b match, trigger, push, pop
  output logic [4:0] ev
);
  int pops_read;
  initial begin
    ev = 5'h00;
    pops_read = 0;
  end
  // one-cycle pulse on each selected event line
  task pulse(input logic [4:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 5'h00;
    if (m[4]) pops_read++;
  endtask
endmodule // trace_source
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the debug run status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import debug_run_status_pkg::*;
  logic ref_clk, srst, hsel, hwrite, chip_secured;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic hreadyout, hresp, armed_out, cpu_break_req, cpu_break_tag, irq;
  logic [4:0] ev;
  int bad_count, checks_done, brk_count;
  trace_source src (.ref_clk(ref_clk), .ev(ev));
  debug_run_status dut (.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_a_match(ev[0]),
    .cmp_b_match(ev[1]), .trigger_event(ev[2]), .fifo_push(ev[3]), .fifo_pop(ev[4]),
    .chip_secured(chip_secured), .armed_out(armed_out), .cpu_break_req(cpu_break_req),
    .cpu_break_tag(cpu_break_tag), .irq(irq));
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (cpu_break_req === 1'b1) brk_count++;
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // one single transfer; the caller's next call leaves an idle cycle
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    {hsel, htrans, hwrite, haddr, hsize} <= {1'b1, 2'b10, w, 24'h0, a, 3'h2};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata, hsize} <= {1'b0, 2'b00, d, 3'h0};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    cmp(n, e, r);
  endtask
  task s_reset;
    rd("status", STAT_OFS, 32'h00);
    rd("unmapped", 8'h40, 32'h00);
  endtask
  task s_end_trace;
    wr(MODE_OFS, 32'h00);
    wr(CTRL_OFS, 32'hd0);
    src.pulse(5'h01);
    src.pulse(5'h02);
    repeat (3) src.pulse(5'h08);
    rd("status armed", STAT_OFS, 32'he3);
    src.pulse(5'h04);
    rd("status ended", STAT_OFS, 32'hc3);
    cmp("breaks", 32'h1, brk_count);
    src.pulse(5'h10);
    wr(STAT_OFS, 32'hff);
    rd("status kept", STAT_OFS, 32'hc3);
  endtask
  task s_begin_trace;
    wr(MODE_OFS, 32'h01);
    wr(CTRL_OFS, 32'he0);
    src.pulse(5'h04);
    rd("status new run", STAT_OFS, 32'h20);
    cmp("break tag", 32'h1, cpu_break_tag);
    repeat (9) src.pulse(5'h08);
    rd("status full", STAT_OFS, 32'h08);
  endtask
  task s_stop;
    wr(MODE_OFS, 32'h00);
    wr(CTRL_OFS, 32'hc0);
    src.pulse(5'h08);
    wr(CTRL_OFS, 32'h80);
    rd("status arm off", STAT_OFS, 32'h01);
    wr(CTRL_OFS, 32'hc0);
    wr(CTRL_OFS, 32'h40);
    rd("status enable off", STAT_OFS, 32'h00);
  endtask
  task s_irq;
    cmp("irq masked", 32'h0, irq);
    rd("irq status", IRQ_STAT_OFS, 32'h07);
    wr(IRQ_MASK_OFS, 32'h01);
    @(negedge ref_clk);
    cmp("irq raised", 32'h1, irq);
    wr(IRQ_STAT_OFS, 32'h07);
    rd("irq cleared", IRQ_STAT_OFS, 32'h00);
    cmp("irq low", 32'h0, irq);
  endtask
  task s_secure;
    chip_secured <= 1'b1;
    repeat (6) @(posedge ref_clk);
    wr(CTRL_OFS, 32'h80);
    rd("control secured", CTRL_OFS, 32'h00);
  endtask
  task test_done;
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {srst, hsel, htrans, hwrite, haddr, hwdata, chip_secured, hsize} = {1'b1, 72'h0};
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    s_reset;
    s_end_trace;
    s_begin_trace;
    s_stop;
    s_irq;
    s_secure;
    test_done;
  end
  initial begin
    #20000;
    bad_count++;
    test_done;
  end
endmodule // testbench
bind debug_run_status debug_run_status_monitor mon (.ref_clk(ref_clk), .srst(srst),
  .hreadyout(hreadyout), .hresp(hresp), .trigger_event(trigger_event),
  .armed_out(armed_out), .cpu_break_req(cpu_break_req), .irq(irq));
`default_nettype wire
